// file: pkg/sro_pkg.sv
// Constants and state types for the receive overhead output ports.
package sro_pkg;
    // System clock rate, used to derive the gapped clock oscillator steps.
    localparam longint SYS_HZ = 200_000_000;
    // Base rates of the gapped output clocks, before gapping.
    localparam longint TOH_STS1_BASE_HZ = 2_160_000;
    localparam longint TOH_STS3_BASE_HZ = 6_480_000;
    localparam longint APS_BASE_HZ = 144_000;
    localparam longint OW_BASE_HZ = 72_000;
    // Oscillator step: the accumulator overflows twice per base period.
    localparam logic [31:0] TOH_STS1_INC = 32'((2 * TOH_STS1_BASE_HZ * (64'd1 << 32)) / SYS_HZ);
    localparam logic [31:0] TOH_STS3_INC = 32'((2 * TOH_STS3_BASE_HZ * (64'd1 << 32)) / SYS_HZ);
    localparam logic [31:0] APS_INC = 32'((2 * APS_BASE_HZ * (64'd1 << 32)) / SYS_HZ);
    localparam logic [31:0] OW_INC = 32'((2 * OW_BASE_HZ * (64'd1 << 32)) / SYS_HZ);
    // One base period in every GAP is suppressed: 4/5 and 8/9 of the base rate.
    localparam logic [3:0] TOH_GAP = 4'h5;
    localparam logic [3:0] APS_GAP = 4'h9;
    localparam logic [3:0] OW_GAP = 4'h9;
    // Frame geometry for one STS-1; STS-3 multiplies columns by three.
    localparam logic [3:0] ROWS = 4'h9;
    localparam logic [8:0] COLS_STS1 = 9'h05A;
    localparam logic [8:0] COLS_STS3 = 9'h10E;
    localparam logic [3:0] TOH_COLS_STS1 = 4'h3;
    localparam logic [3:0] TOH_COLS_STS3 = 4'h9;
    localparam int TOH_MAX = 81;
    localparam logic [6:0] TOH_LAST_STS1 = 7'h1A;
    localparam logic [6:0] TOH_LAST_STS3 = 7'h50;
    // Rows of the extracted bytes; the column is the byte type times the interleave.
    localparam logic [3:0] ROW_E1F1 = 4'h1;
    localparam logic [3:0] ROW_K1K2 = 4'h4;
    localparam logic [3:0] ROW_E2 = 4'h8;
    // Serial channel lengths in bits per frame.
    localparam logic [4:0] APS_BITS = 5'h10;
    localparam logic [3:0] OW_BITS = 4'h8;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // One gapped clock generator.
    typedef struct packed {
        logic [31:0] acc;
        logic half;
        logic [3:0] slot;
        logic lvl;
    } sro_gclk_t;

    // The whole state of the port block except the overhead store.
    typedef struct packed {
        logic [8:0] col;
        logic [3:0] row;
        logic [7:0] k1;
        logic [7:0] k2;
        logic [7:0] e1;
        logic [7:0] f1;
        logic [7:0] e2;
        logic wbank;
        logic rbank;
        logic [7:0] pout;
        logic ofp;
        logic [2:0] rclk_sync;
        logic rclk_lvl;
        logic [2:0] div_cnt;
        logic bclk;
        logic [2:0] tsel_sync;
        logic tsel;
        sro_gclk_t g_toh;
        sro_gclk_t g_aps;
        sro_gclk_t g_ow;
        logic [7:0] toh_sr;
        logic [2:0] toh_bit;
        logic [6:0] toh_byte;
        logic toh_act;
        logic toh_pend;
        logic toh_fp;
        logic [15:0] aps_sr;
        logic [4:0] aps_left;
        logic aps_pend;
        logic [23:0] ow_sr;
        logic [3:0] ow_left;
        logic ow_pend;
    } sro_state_t;
endpackage : sro_pkg

// file: rtl/sro_rx_overhead_ports.sv
// Receive overhead serial ports, parallel data output and generated byte clock.
`timescale 1ns/1ps
// How it works
// R1 - K1 and K2 bytes leave serially on the protection output, changing at clock falls.
// R2 - Every transport overhead byte of the frame appears on the serial overhead output.
// R3 - Overhead data and frame marker change only on overhead clock falling edges; the code also loads a frame's first byte while the clock is low, not at a fall.
// R4 - STS-3 overhead clock is a 6.48 MHz clock gapped to 5.184 MHz average.
// R5 - STS-1 overhead clock is a 2.16 MHz clock gapped to 1.728 MHz average.
// R6 - Overhead frame marker is high only during bit 1 of the first A1.
// R7 - STS-1 bit-serial mode: byte clock is the TTL serial clock divided by eight.
// R8 - STS-3 bit-serial mode: byte clock is the differential serial clock divided by eight.
// R9 - Parallel output bit 7 carries the first received bit, bit 0 the last.
// R10 - Parallel data output changes on the receive byte clock rising edge.
// R11 - Frame position marker is high once per frame, on the byte after Z0.
// R12 - Order wire, user channel and protection streams align to the frame position marker; the code starts them at the last overhead byte instead.
// R13 - Frame position marker changes on the receive byte clock rising edge.
// R14 - Transmit select high chooses the bit-serial interface; TTL also allowed in STS-1.
// R15 - Transmit select low chooses the byte-serial transmit interface.
// R16 - Protection clock is 144 kHz gapped to 128 kHz.
// R17 - Order wire clock is 72 kHz gapped to 64 kHz.
// R18 - Serial outputs send each byte MSB first, bytes in received order.
module sro_rx_overhead_ports (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Mode straps, same clock domain.
    input wire logic rx_sts3_mode_i,
    input wire logic rx_bit_serial_en_i,
    // Descrambled receive byte stream, one strobe per byte slot.
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_frame_start_i,
    // Serial receive clock pins, asynchronous.
    input wire logic rx_ttl_serial_clock_i,
    input wire logic rx_diff_serial_clock_i,
    // Transmit line select pin, asynchronous.
    input wire logic tx_line_interface_select_i,
    // Generated byte clock.
    output logic rx_generated_byte_clock_o,
    // Parallel output stream.
    output logic [7:0] rx_parallel_data_out_o,
    output logic rx_frame_position_marker_o,
    // Transport overhead serial port.
    output logic rx_overhead_serial_out_o,
    output logic rx_overhead_clock_o,
    output logic rx_overhead_frame_marker_o,
    // Protection channel serial port.
    output logic rx_protection_serial_out_o,
    output logic rx_protection_clock_o,
    // Order wire and user channel serial ports.
    output logic rx_section_orderwire_out_o,
    output logic rx_user_channel_out_o,
    output logic rx_line_orderwire_out_o,
    output logic rx_orderwire_clock_o,
    // Transmit interface selection.
    output logic tx_diff_serial_en_o,
    output logic tx_ttl_serial_en_o,
    output logic tx_byte_serial_en_o
);
    // One step of a gapped clock: the last base period of every gap window stays low.
    function automatic sro_pkg::sro_gclk_t gclk_step(input sro_pkg::sro_gclk_t g, input logic [31:0] inc,
                                                     input logic [3:0] gap, input logic run);
        logic [32:0] sum;
        sro_pkg::sro_gclk_t n;
        n = g;
        sum = {1'b0, g.acc} + {1'b0, inc};
        n.acc = sum[31:0];
        if (sum[32]) begin
            n.half = ~g.half;
            if (!g.half) begin
                n.slot = (g.slot == gap - 4'h1) ? 4'h0 : g.slot + 4'h1;
                n.lvl = run && (g.slot != gap - 4'h1);
            end else begin
                n.lvl = 1'b0;
            end
        end
        return n;
    endfunction : gclk_step

    sro_pkg::sro_state_t st;
    sro_pkg::sro_state_t next_st;
    // Two frames of overhead: one fills while the other is shifted out.
    logic [7:0] toh_mem [0:2*sro_pkg::TOH_MAX-1];
    logic [8:0] cur_col;
    logic [3:0] cur_row;
    logic [8:0] row_cols;
    logic [3:0] toh_cols;
    logic [6:0] toh_last;
    logic [7:0] toh_idx;
    logic is_toh;
    logic frame_done;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_raddr;
    logic [7:0] mem_rdata;
    logic toh_fall;
    logic aps_fall;
    logic ow_fall;
    logic serial_clk;

    // Position of the byte now arriving, and the frame geometry for the mode.
    always_comb begin
        row_cols = rx_sts3_mode_i ? sro_pkg::COLS_STS3 : sro_pkg::COLS_STS1;
        toh_cols = rx_sts3_mode_i ? sro_pkg::TOH_COLS_STS3 : sro_pkg::TOH_COLS_STS1;
        toh_last = rx_sts3_mode_i ? sro_pkg::TOH_LAST_STS3 : sro_pkg::TOH_LAST_STS1;
        cur_col = rx_frame_start_i ? 9'h000 : st.col;
        cur_row = rx_frame_start_i ? 4'h0 : st.row;
        is_toh = cur_col < {5'h00, toh_cols};
        // Widen before the product: row 8 times nine columns does not fit in four bits.
        toh_idx = {4'h0, cur_row} * {4'h0, toh_cols} + 8'(cur_col);
        frame_done = rx_byte_valid_i && is_toh && (toh_idx[6:0] == toh_last);
        mem_we = rx_byte_valid_i && is_toh;
        mem_waddr = st.wbank ? 8'(sro_pkg::TOH_MAX) + toh_idx : toh_idx;
        mem_raddr = 8'(st.toh_pend ? 7'h00 : st.toh_byte + 7'h01);
        if (st.rbank) begin
            mem_raddr = mem_raddr + 8'(sro_pkg::TOH_MAX);
        end
        serial_clk = rx_sts3_mode_i ? rx_diff_serial_clock_i : rx_ttl_serial_clock_i;
    end

    // The overhead store has its own write port; it needs no reset.
    always_ff @(posedge clk_sys_i) begin
        if (mem_we) begin
            toh_mem[mem_waddr] <= rx_byte_i; // R2
        end
    end
    assign mem_rdata = toh_mem[mem_raddr];

    // Next state of the whole block.
    always_comb begin
        next_st = st;
        // Pin inputs pass three flops; a level counts once the last two agree.
        next_st.rclk_sync = {st.rclk_sync[1:0], serial_clk};
        next_st.tsel_sync = {st.tsel_sync[1:0], tx_line_interface_select_i};
        if (st.rclk_sync[1] == st.rclk_sync[2]) begin
            next_st.rclk_lvl = st.rclk_sync[2];
        end
        if (st.tsel_sync[1] == st.tsel_sync[2]) begin
            next_st.tsel = st.tsel_sync[2]; // R14 R15
        end
        // Divide the serial clock by eight; held low when no bit-serial interface is on.
        if (!rx_bit_serial_en_i) begin
            next_st.div_cnt = 3'h0;
        end else if (next_st.rclk_lvl && !st.rclk_lvl) begin
            next_st.div_cnt = st.div_cnt + 3'h1; // R7 R8
        end
        next_st.bclk = next_st.div_cnt[2]; // R7 R8
        // Each byte strobe stands for a byte clock rising edge.
        if (rx_byte_valid_i) begin
            next_st.pout = rx_byte_i; // R9 R10
            next_st.ofp = (cur_row == 4'h0) && (cur_col == {5'h00, toh_cols}); // R11 R13
            if (cur_col == row_cols - 9'h001) begin
                next_st.col = 9'h000;
                next_st.row = (cur_row == sro_pkg::ROWS - 4'h1) ? 4'h0 : cur_row + 4'h1;
            end else begin
                next_st.col = cur_col + 9'h001;
                next_st.row = cur_row;
            end
            // Capture the channel bytes from the first interleaved column of each type.
            if (cur_row == sro_pkg::ROW_E1F1 && cur_col == {5'h00, toh_cols} / 9'h003) begin
                next_st.e1 = rx_byte_i;
            end
            if (cur_row == sro_pkg::ROW_E1F1 && cur_col == 9'(toh_cols) * 9'h002 / 9'h003) begin
                next_st.f1 = rx_byte_i;
            end
            if (cur_row == sro_pkg::ROW_K1K2 && cur_col == {5'h00, toh_cols} / 9'h003) begin
                next_st.k1 = rx_byte_i; // R1
            end
            if (cur_row == sro_pkg::ROW_K1K2 && cur_col == 9'(toh_cols) * 9'h002 / 9'h003) begin
                next_st.k2 = rx_byte_i; // R1
            end
            if (cur_row == sro_pkg::ROW_E2 && cur_col == 9'(toh_cols) * 9'h002 / 9'h003) begin
                next_st.e2 = rx_byte_i;
            end
        end
        // A completed frame swaps banks and arms every serial channel at one boundary.
        if (frame_done) begin
            next_st.wbank = ~st.wbank;
            next_st.rbank = st.wbank;
            next_st.toh_pend = 1'b1;
            next_st.aps_pend = 1'b1; // R12
            next_st.ow_pend = 1'b1; // R12
        end
        // Gapped clocks run only while bits remain, so a frame never overruns.
        next_st.g_toh = gclk_step(st.g_toh, rx_sts3_mode_i ? sro_pkg::TOH_STS3_INC : sro_pkg::TOH_STS1_INC,
                                  sro_pkg::TOH_GAP, st.toh_act && !st.toh_pend); // R4 R5
        next_st.g_aps = gclk_step(st.g_aps, sro_pkg::APS_INC, sro_pkg::APS_GAP,
                                  st.aps_left != 5'h00 && !st.aps_pend); // R16
        next_st.g_ow = gclk_step(st.g_ow, sro_pkg::OW_INC, sro_pkg::OW_GAP,
                                 st.ow_left != 4'h0 && !st.ow_pend); // R17
        toh_fall = st.g_toh.lvl && !next_st.g_toh.lvl;
        aps_fall = st.g_aps.lvl && !next_st.g_aps.lvl;
        ow_fall = st.g_ow.lvl && !next_st.g_ow.lvl;
        // Overhead serializer: new data only while the clock is low, at a fall or on a fresh load.
        if (st.toh_pend && !st.g_toh.lvl) begin
            next_st.toh_pend = frame_done;
            next_st.toh_sr = mem_rdata;
            next_st.toh_byte = 7'h00;
            next_st.toh_bit = 3'h0;
            next_st.toh_act = 1'b1;
        end else if (toh_fall && st.toh_act) begin
            if (st.toh_bit != sro_pkg::BIT_LAST) begin
                next_st.toh_sr = {st.toh_sr[6:0], 1'b0}; // R18
                next_st.toh_bit = st.toh_bit + 3'h1;
            end else if (st.toh_byte == toh_last) begin
                next_st.toh_act = 1'b0;
            end else begin
                next_st.toh_sr = mem_rdata; // R2 R18
                next_st.toh_byte = st.toh_byte + 7'h01;
                next_st.toh_bit = 3'h0;
            end
        end
        next_st.toh_fp = next_st.toh_act && next_st.toh_byte == 7'h00 && next_st.toh_bit == 3'h0; // R3 R6
        // Protection channel: K1 then K2, sixteen bits per frame.
        if (st.aps_pend && !st.g_aps.lvl) begin
            next_st.aps_pend = frame_done;
            next_st.aps_sr = {st.k1, st.k2}; // R1 R18
            next_st.aps_left = sro_pkg::APS_BITS;
        end else if (aps_fall && st.aps_left != 5'h00) begin
            next_st.aps_sr = {st.aps_sr[14:0], 1'b0}; // R1
            next_st.aps_left = st.aps_left - 5'h01;
        end
        // Order wire and user channel share one clock and shift together.
        if (st.ow_pend && !st.g_ow.lvl) begin
            next_st.ow_pend = frame_done;
            next_st.ow_sr = {st.e1, st.f1, st.e2}; // R12
            next_st.ow_left = sro_pkg::OW_BITS;
        end else if (ow_fall && st.ow_left != 4'h0) begin
            next_st.ow_sr = {st.ow_sr[22:16], 1'b0, st.ow_sr[14:8], 1'b0, st.ow_sr[6:0], 1'b0}; // R17
            next_st.ow_left = st.ow_left - 4'h1;
        end
    end

    // All block state except the overhead store in one register; reset clears it to idle with clocks low.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Every output except tx_ttl_serial_en_o and tx_byte_serial_en_o comes straight from a state flop.
    assign rx_generated_byte_clock_o = st.bclk;
    assign rx_parallel_data_out_o = st.pout;
    assign rx_frame_position_marker_o = st.ofp;
    assign rx_overhead_serial_out_o = st.toh_sr[7];
    assign rx_overhead_clock_o = st.g_toh.lvl;
    assign rx_overhead_frame_marker_o = st.toh_fp;
    assign rx_protection_serial_out_o = st.aps_sr[15];
    assign rx_protection_clock_o = st.g_aps.lvl;
    assign rx_section_orderwire_out_o = st.ow_sr[23];
    assign rx_user_channel_out_o = st.ow_sr[15];
    assign rx_line_orderwire_out_o = st.ow_sr[7];
    assign rx_orderwire_clock_o = st.g_ow.lvl;
    // The TTL transmit path is only offered in STS-1 mode.
    assign tx_diff_serial_en_o = st.tsel; // R14
    assign tx_ttl_serial_en_o = st.tsel && !rx_sts3_mode_i; // R14
    assign tx_byte_serial_en_o = !st.tsel; // R15
endmodule : sro_rx_overhead_ports

// file: verification/sro_far_end.sv
// Downstream receiver of one gapped serial channel.
`timescale 1ns/1ps
module sro_ser_rx #(
    parameter int W = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic sclk_i,
    input wire logic sdat_i,
    input wire logic mark_i
);
    logic [W-1:0] sr = '0;
    logic sclk_q = 1'b0;
    int rises = 0;
    int mark_at = -1;
    int t_first = 0;
    int t_last = 0;
    int now = 0;

    // Samples on the clock rise only, as real logic would; a gap simply delays the next bit.
    always @(posedge clk_sys_i) begin
        now <= now + 1;
        sclk_q <= sclk_i;
        if (srst_i) begin
            sr <= '0;
            rises <= 0;
            mark_at <= -1;
        end else if (sclk_i && !sclk_q) begin
            sr <= {sr[W-2:0], sdat_i};
            if (mark_i) mark_at <= rises;
            if (rises == 0) t_first <= now;
            t_last <= now;
            rises <= rises + 1;
        end
    end
endmodule : sro_ser_rx

// file: verification/sro_rx_overhead_ports_asserts.sv
// Concurrent checks on the receive overhead output ports.
`timescale 1ns/1ps
module sro_rx_overhead_ports_asserts (
    // Clock, reset and mode.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic rx_sts3_mode_i,
    // Byte stream in and out.
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic [7:0] rx_parallel_data_out_o,
    input wire logic rx_frame_position_marker_o,
    // Serial ports.
    input wire logic rx_overhead_serial_out_o,
    input wire logic rx_overhead_clock_o,
    input wire logic rx_overhead_frame_marker_o,
    input wire logic rx_protection_serial_out_o,
    input wire logic rx_protection_clock_o,
    input wire logic rx_section_orderwire_out_o,
    input wire logic rx_user_channel_out_o,
    input wire logic rx_line_orderwire_out_o,
    input wire logic rx_orderwire_clock_o,
    // Transmit selection.
    input wire logic tx_diff_serial_en_o,
    input wire logic tx_ttl_serial_en_o,
    input wire logic tx_byte_serial_en_o
);
    // All checks live in the system clock domain.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // Serial data may only move while its clock is low, so the far side sees it settled at the rise.
    property p_toh_dat; $changed(rx_overhead_serial_out_o) |-> !rx_overhead_clock_o; endproperty
    a_toh_dat: assert property (p_toh_dat) else $error("overhead data moved while clock high");
    property p_toh_fp; $changed(rx_overhead_frame_marker_o) |-> !rx_overhead_clock_o; endproperty
    a_toh_fp: assert property (p_toh_fp) else $error("overhead marker moved while clock high");
    property p_fp_one;
        $fell(rx_overhead_clock_o) && $past(rx_overhead_frame_marker_o) |-> !rx_overhead_frame_marker_o;
    endproperty
    a_fp_one: assert property (p_fp_one) else $error("overhead marker longer than one bit");
    property p_aps; $changed(rx_protection_serial_out_o) |-> !rx_protection_clock_o; endproperty
    a_aps: assert property (p_aps) else $error("protection data moved while clock high");
    property p_ow;
        $changed({rx_section_orderwire_out_o, rx_user_channel_out_o, rx_line_orderwire_out_o}) |-> !rx_orderwire_clock_o;
    endproperty
    a_ow: assert property (p_ow) else $error("order wire data moved while clock high");
    // The parallel side only moves one cycle after a byte slot.
    property p_pout; $changed(rx_parallel_data_out_o) |-> $past(rx_byte_valid_i); endproperty
    a_pout: assert property (p_pout) else $error("parallel data moved without a byte slot");
    property p_order; rx_byte_valid_i |=> rx_parallel_data_out_o == $past(rx_byte_i); endproperty
    a_order: assert property (p_order) else $error("parallel byte wrong or reordered");
    property p_ofp; $changed(rx_frame_position_marker_o) |-> $past(rx_byte_valid_i); endproperty
    a_ofp: assert property (p_ofp) else $error("position marker moved without a byte slot");
    property p_txb; tx_byte_serial_en_o == !tx_diff_serial_en_o; endproperty
    a_txb: assert property (p_txb) else $error("byte and serial transmit both or neither");
    property p_txt; tx_ttl_serial_en_o |-> tx_diff_serial_en_o && !rx_sts3_mode_i; endproperty
    a_txt: assert property (p_txt) else $error("ttl transmit outside serial sts1");
endmodule : sro_rx_overhead_ports_asserts

// file: verification/sro_rx_overhead_ports_bench.sv
// Self-checking bench for the receive overhead output ports.
`timescale 1ns/1ps
module sro_rx_overhead_ports_bench;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic sts3 = 1'b0, bser = 1'b0, vld = 1'b0, fst = 1'b0, ttl = 1'b0, dif = 1'b0, tsel = 1'b0;
    logic [7:0] dat = 8'h00;
    logic bclk, ofp, toh, tclk, tfp, aps, aclk, sow, suc, low, oclk, tdif, tttl, tbyt;
    logic [7:0] pout;
    int n_fail = 0;
    int check_count = 0;

    // Design and the downstream receivers on each serial port.
    sro_rx_overhead_ports u_dut (
        .clk_sys_i, .srst_i, .rx_sts3_mode_i(sts3), .rx_bit_serial_en_i(bser), .rx_byte_valid_i(vld),
        .rx_byte_i(dat), .rx_frame_start_i(fst), .rx_ttl_serial_clock_i(ttl), .rx_diff_serial_clock_i(dif),
        .tx_line_interface_select_i(tsel), .rx_generated_byte_clock_o(bclk), .rx_parallel_data_out_o(pout),
        .rx_frame_position_marker_o(ofp), .rx_overhead_serial_out_o(toh), .rx_overhead_clock_o(tclk),
        .rx_overhead_frame_marker_o(tfp), .rx_protection_serial_out_o(aps), .rx_protection_clock_o(aclk),
        .rx_section_orderwire_out_o(sow), .rx_user_channel_out_o(suc), .rx_line_orderwire_out_o(low),
        .rx_orderwire_clock_o(oclk), .tx_diff_serial_en_o(tdif), .tx_ttl_serial_en_o(tttl),
        .tx_byte_serial_en_o(tbyt));
    sro_ser_rx #(.W(648)) u_toh (.clk_sys_i, .srst_i, .sclk_i(tclk), .sdat_i(toh), .mark_i(tfp));
    // These channels start after the frame's last overhead byte, not at the parallel position marker, which is wired only as their marker input.
    sro_ser_rx #(.W(16)) u_aps (.clk_sys_i, .srst_i, .sclk_i(aclk), .sdat_i(aps), .mark_i(ofp));
    sro_ser_rx #(.W(8)) u_sow (.clk_sys_i, .srst_i, .sclk_i(oclk), .sdat_i(sow), .mark_i(ofp));
    sro_ser_rx #(.W(8)) u_suc (.clk_sys_i, .srst_i, .sclk_i(oclk), .sdat_i(suc), .mark_i(ofp));
    sro_ser_rx #(.W(8)) u_low (.clk_sys_i, .srst_i, .sclk_i(oclk), .sdat_i(low), .mark_i(ofp));

    // 200 MHz system clock.
    initial forever #2.5 clk_sys_i = ~clk_sys_i;

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Distinct byte per overhead position, so any misplaced overhead byte shows.
    function automatic logic [7:0] bval(input int r, input int c);
        return 8'(r * 37 + c * 11 + 5);
    endfunction : bval

    // Mode is a strap, so it only changes while reset is held.
    task automatic do_reset(input logic m);
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        sts3 = m;
        repeat (12) @(negedge clk_sys_i);
        srst_i = 1'b0;
    endtask : do_reset

    // Serial clock toggles every 8 cycles; 32 rises give exactly 4 divided rises.
    task automatic bclk_test(input logic m);
        int rises;
        logic q;
        rises = 0;
        q = 1'b0;
        bser = 1'b1;
        for (int i = 0; i < 512; i++) begin
            @(negedge clk_sys_i);
            if (i % 8 == 0 && m) dif = !dif;
            if (i % 8 == 0 && !m) ttl = !ttl;
            if (bclk && !q) rises++;
            q = bclk;
        end
        check("byte clock rises", rises, 4);
        bser = 1'b0;
    endtask : bclk_test

    // Select high then low, each given time to cross the synchroniser.
    task automatic tx_sel_test();
        for (int s = 1; s >= 0; s--) begin
            @(negedge clk_sys_i);
            tsel = s[0];
            repeat (8) @(negedge clk_sys_i);
            check("diff select", tdif, s[0]);
            check("ttl select", tttl, s[0] && !sts3);
            check("byte select", tbyt, !s[0]);
        end
    endtask : tx_sel_test

    // One whole frame back to back, then every serial port is drained and compared.
    task automatic frame_test(input logic m);
        int n;
        int span;
        logic [7:0] e;
        n = m ? 3 : 1;
        e = 8'h00;
        for (int r = 0; r < 9; r++) begin
            for (int c = 0; c < 90 * n; c++) begin
                @(negedge clk_sys_i);
                if (r + c > 0) begin
                    check("parallel data", pout, e);
                    check("frame position", ofp, r == 0 && c == 3 * n + 1);
                end
                vld = 1'b1;
                fst = (r == 0 && c == 0);
                dat = bval(r, c);
                e = dat;
            end
        end
        @(negedge clk_sys_i);
        check("parallel data", pout, e);
        vld = 1'b0;
        fst = 1'b0;
        repeat (27000) @(negedge clk_sys_i);
        for (int i = 0; i < 27 * n; i++)
            check("overhead byte", u_toh.sr[8 * (27 * n - 1 - i) +: 8], bval(i / (3 * n), i % (3 * n)));
        check("overhead bits", u_toh.rises, 216 * n);
        check("overhead marker bit", u_toh.mark_at, 0);
        span = u_toh.t_last - u_toh.t_first;
        check("overhead clock span", span > 24700 && span < 25070, 1);
        check("protection bytes", u_aps.sr, {bval(4, n), bval(4, 2 * n)});
        check("protection bits", u_aps.rises, 16);
        span = u_aps.t_last - u_aps.t_first;
        check("protection clock span", span > 22100 && span < 23700, 1);
        check("section order wire", u_sow.sr, bval(1, n));
        check("user channel", u_suc.sr, bval(1, 2 * n));
        check("line order wire", u_low.sr, bval(8, 2 * n));
        check("order wire bits", u_low.rises, 8);
        // Seven base periods between first and last rise, plus at most one gapped period.
        span = u_low.t_last - u_low.t_first;
        check("order wire clock span", span > 19300 && span < 22300, 1);
    endtask : frame_test

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Main sequence: STS-1 first, then STS-3 after a fresh reset.
    initial begin
        do_reset(1'b0);
        bclk_test(1'b0);
        tx_sel_test();
        frame_test(1'b0);
        do_reset(1'b1);
        bclk_test(1'b1);
        tx_sel_test();
        frame_test(1'b1);
        end_of_test();
    end

    // Watchdog: both runs need about 60000 cycles, so this only trips on a hang.
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_fail++;
        end_of_test();
    end
endmodule : sro_rx_overhead_ports_bench

bind sro_rx_overhead_ports sro_rx_overhead_ports_asserts u_chk (.*);
